// ==== rtl/wdt_top.sv ====
// Watchdog downcounter with prescaler, control register and reset pulse
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module wdt_top (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire wdt_pkg::wdt_bus_t bus,
  input  wire logic             haltExec,
  input  wire logic             hwWatchdogOption,
  input  wire logic             haltResetSuppressOption,
  output logic [7:0]            rdata,
  output logic                  chipReset,
  output logic                  resetPinLow_n
);

  ////////////////////////////////////////////////////////////////////////////
  wdt_pkg::wdt_regs_t sReg;
  wdt_pkg::wdt_regs_t sNext;
  logic               activeEff;
  logic               tick;
  logic [6:0]         countStep;
  logic               trip;
  logic               wrHit;
  logic               rdHit;

  // Control register decode, shared by the logic and the checks
  function automatic logic ctrlHit(input logic [3:0] addr);
    return addr == wdt_pkg::CTRL_ADDR;
  endfunction

  // Strobes aimed at the control register; other addresses do nothing
  assign wrHit = bus.wr && ctrlHit(bus.addr);
  assign rdHit = bus.rd && ctrlHit(bus.addr);

  // Forced-on option overrides the software bit
  assign activeEff = sReg.active | hwWatchdogOption;
  // Prescaler is never cleared by writes, so timeout jitters by one period
  assign tick = (sReg.prescale == wdt_pkg::PRESCALE_LAST);

  // Next state of the whole block
  always_comb begin
    sNext = sReg;
    trip  = 1'b0;
    countStep = sReg.count;
    sNext.prescale = tick ? 14'h0000 : sReg.prescale + 14'h0001;
    if (tick) begin
      countStep = sReg.count - 7'h01;
    end
    // A fall of the top bit on a step is the timeout
    if (tick && sReg.count == 7'h40 && activeEff) begin
      trip = 1'b1;
    end
    sNext.count = countStep;
    if (wrHit) begin
      // Write loads the count; activation can only be set
      sNext.count  = bus.wdata[6:0];
      sNext.active = sReg.active | bus.wdata[wdt_pkg::ACT_BIT];
      if ((bus.wdata[wdt_pkg::ACT_BIT] | activeEff) &&
          !bus.wdata[wdt_pkg::TOP_BIT]) begin
        trip = 1'b1;
      end
    end
    if (haltExec && activeEff && !haltResetSuppressOption) begin
      trip = 1'b1;
    end
    sNext.rdata = 8'h00;
    if (rdHit) begin
      sNext.rdata = {sReg.active, sReg.count};
    end
    sNext.chipReset = 1'b0;
    case (sReg.state)
      wdt_pkg::WDT_RUN: begin
        sNext.resetPinLow = 1'b0;
        if (trip) begin
          sNext.state       = wdt_pkg::WDT_PULSE;
          sNext.pulse       = 12'h000;
          sNext.resetPinLow = 1'b1;
          sNext.chipReset   = 1'b1;
        end
      end
      wdt_pkg::WDT_PULSE: begin
        // Pin held low for a fixed time, then the block restarts itself
        if (sReg.pulse == wdt_pkg::RST_PULSE_CYC - 12'h001) begin
          sNext.state       = wdt_pkg::WDT_RUN;
          sNext.resetPinLow = 1'b0;
          sNext.active      = 1'b0;
          sNext.count       = wdt_pkg::CTRL_RESET[6:0];
        end else begin
          sNext.pulse = sReg.pulse + 12'h001;
        end
      end
      default: sNext.state = wdt_pkg::WDT_RUN;
    endcase
  end

  // State register; synchronous reset brings the register to 7Fh
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sReg <= '{state: wdt_pkg::WDT_RUN, active: 1'b0,
                count: wdt_pkg::CTRL_RESET[6:0], prescale: 14'h0000,
                pulse: 12'h000, resetPinLow: 1'b0, chipReset: 1'b0,
                rdata: 8'h00};
    end else begin
      sReg <= sNext;
    end
  end

  assign rdata         = sReg.rdata;
  assign chipReset     = sReg.chipReset;
  assign resetPinLow_n = ~sReg.resetPinLow;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  timeout_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sReg.state == wdt_pkg::WDT_RUN && tick && sReg.count == 7'h40 &&
     activeEff) |=> chipReset)
    else $error("timeout did not reset");
  free_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !bus.wr && sReg.state == wdt_pkg::WDT_RUN &&
     !(sReg.count == 7'h40 && activeEff) && !haltExec) |=>
     sReg.count == $past(sReg.count) - 7'h01)
    else $error("count did not step");
  no_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sReg.active && sReg.state == wdt_pkg::WDT_RUN) |=> sReg.active)
    else $error("activation bit cleared");
  sw_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == wdt_pkg::CTRL_ADDR && bus.wdata[7] &&
     !bus.wdata[6] && sReg.state == wdt_pkg::WDT_RUN) |=> chipReset)
    else $error("software reset missed");
  halt_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (haltExec && activeEff && !haltResetSuppressOption &&
     sReg.state == wdt_pkg::WDT_RUN) |=> chipReset)
    else $error("halt reset missed");
  load_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == wdt_pkg::CTRL_ADDR && bus.wdata[6] &&
     sReg.state == wdt_pkg::WDT_RUN && !haltExec) |=>
     sReg.count == $past(bus.wdata[6:0]))
    else $error("count not loaded");
  read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && bus.addr == wdt_pkg::CTRL_ADDR) |=>
     rdata == {$past(sReg.active), $past(sReg.count)})
    else $error("read data wrong");
  pulse_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sReg.resetPinLow) |=> !resetPinLow_n [*8])
    else $error("reset pulse too short");
  prescale_a: assert property (@(posedge clk) disable iff (!rst_n)
    sReg.prescale <= wdt_pkg::PRESCALE_LAST)
    else $error("prescaler out of range");
  hw_option_a: assert property (@(posedge clk) disable iff (!rst_n)
    (hwWatchdogOption && haltExec && !haltResetSuppressOption &&
     sReg.state == wdt_pkg::WDT_RUN) |=> chipReset)
    else $error("hardware option ignored");

  ////////////////////////////////////////////////////////////////////////////
  // Finer checks on the bus, the reset pulse and the prescaler.
  // Antecedents leave out the other trip sources on purpose, so that
  // each check pins one cause to one effect and cannot fail by accident.
  // Checks that look back across reset sample rst_n in their antecedent.

  // Read data are zero whenever no read of the register was taken
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rdHit |=> rdata == 8'h00)
    else $error("idle read data not zero");

  // A read returns the stored bit, not the forced-on option
  act_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rdHit && !sReg.active) |=> !rdata[7])
    else $error("read shows forced activation");

  // A read alone leaves the count where it was
  read_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rdHit && !bus.wr && !tick && sReg.state == wdt_pkg::WDT_RUN) |=>
     $stable(sReg.count))
    else $error("read changed count");

  // Writes to other addresses touch nothing
  bad_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && !wrHit && !tick && sReg.state == wdt_pkg::WDT_RUN) |=>
     ($stable(sReg.count) && $stable(sReg.active)))
    else $error("unmapped write took effect");

  // Reset request goes high as the pin goes low
  trip_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    chipReset |-> !resetPinLow_n)
    else $error("pin not low with reset");

  // The reset request is a single-cycle pulse
  reset_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    chipReset |=> !chipReset)
    else $error("reset request too long");

  // Every request opens a pulse
  trip_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    chipReset |-> sReg.state == wdt_pkg::WDT_PULSE)
    else $error("reset without pulse");

  // No second request while the pin is already held
  no_retrip_a: assert property (@(posedge clk) disable iff (!rst_n)
    sReg.state == wdt_pkg::WDT_PULSE |=> !chipReset)
    else $error("reset retriggered in pulse");

  // Pin level follows the pulse state exactly
  pin_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    !resetPinLow_n == (sReg.state == wdt_pkg::WDT_PULSE))
    else $error("pin and state disagree");

  // Pulse counter starts from zero
  pulse_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sReg.resetPinLow) |-> sReg.pulse == 12'h000)
    else $error("pulse counter not cleared");

  // Pulse counter never passes its last value
  pulse_max_a: assert property (@(posedge clk) disable iff (!rst_n)
    sReg.state == wdt_pkg::WDT_PULSE |-> sReg.pulse < wdt_pkg::RST_PULSE_CYC)
    else $error("pulse counter overran");

  // Pin stays low until the last pulse cycle
  stay_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sReg.state == wdt_pkg::WDT_PULSE &&
     sReg.pulse != wdt_pkg::RST_PULSE_CYC - 12'h001) |=> !resetPinLow_n)
    else $error("pin released early");

  // Pulse counter moves by one each cycle
  pulse_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sReg.state == wdt_pkg::WDT_PULSE &&
     sReg.pulse != wdt_pkg::RST_PULSE_CYC - 12'h001) |=>
     sReg.pulse == $past(sReg.pulse) + 12'h001)
    else $error("pulse counter skipped");

  // Pin is released right after the last pulse cycle
  pulse_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sReg.state == wdt_pkg::WDT_PULSE &&
     sReg.pulse == wdt_pkg::RST_PULSE_CYC - 12'h001) |=> resetPinLow_n)
    else $error("pin not released");

  // End of pulse leaves the register as after reset
  pulse_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sReg.state == wdt_pkg::WDT_PULSE &&
     sReg.pulse == wdt_pkg::RST_PULSE_CYC - 12'h001) |=>
     (!sReg.active && sReg.count == wdt_pkg::CTRL_RESET[6:0]))
    else $error("register not restored");

  // Prescaler wraps to zero on its tick
  presc_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> sReg.prescale == 14'h0000)
    else $error("prescaler did not wrap");

  // Prescaler counts on through writes; never cleared by software
  presc_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && !tick) |=> sReg.prescale == $past(sReg.prescale) + 14'h0001)
    else $error("prescaler disturbed");

  // Between ticks in the run state the count only moves on a write
  hold_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!tick && !wrHit && sReg.state == wdt_pkg::WDT_RUN) |=>
     $stable(sReg.count))
    else $error("count moved between ticks");

  // Writing the activation bit sets it
  act_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrHit && bus.wdata[wdt_pkg::ACT_BIT] &&
     sReg.state == wdt_pkg::WDT_RUN) |=> sReg.active)
    else $error("activation not set");

  // Nothing but a write of one sets the activation bit
  act_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!sReg.active && !(wrHit && bus.wdata[wdt_pkg::ACT_BIT])) |=>
     !sReg.active)
    else $error("activation set by itself");

  // Suppress option stops the halt reset
  halt_suppr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (haltExec && haltResetSuppressOption && !bus.wr && !tick &&
     sReg.state == wdt_pkg::WDT_RUN) |=> !chipReset)
    else $error("suppressed halt reset");

  // Halt while inactive does nothing
  halt_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (haltExec && !activeEff && !bus.wr && !tick &&
     sReg.state == wdt_pkg::WDT_RUN) |=> !chipReset)
    else $error("halt reset while inactive");

  // Inactive expiry rolls on to 3Fh with no reset
  idle_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && sReg.count == 7'h40 && !activeEff && !bus.wr &&
     sReg.state == wdt_pkg::WDT_RUN) |=>
     (!chipReset && sReg.count == 7'h3f))
    else $error("inactive expiry wrong");

  // Forced-on option resets on expiry with the bit clear
  hw_expire_a: assert property (@(posedge clk) disable iff (!rst_n)
    (hwWatchdogOption && tick && sReg.count == 7'h40 &&
     sReg.state == wdt_pkg::WDT_RUN) |=> chipReset)
    else $error("forced expiry missed");

  // Forced-on option also honours the software reset
  hw_swreset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (hwWatchdogOption && wrHit && !bus.wdata[wdt_pkg::TOP_BIT] &&
     sReg.state == wdt_pkg::WDT_RUN) |=> chipReset)
    else $error("forced software reset missed");

  // A refresh with the top bit set resets only on a coinciding halt or expiry step
  refresh_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrHit && bus.wdata[wdt_pkg::TOP_BIT] && !haltExec && !tick &&
     sReg.state == wdt_pkg::WDT_RUN) |=> !chipReset)
    else $error("refresh caused reset");

  // Top bit cleared while inactive is no software reset
  sw_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrHit && bus.wdata[7:6] == 2'b00 && !activeEff && !haltExec &&
     !tick && sReg.state == wdt_pkg::WDT_RUN) |=> !chipReset)
    else $error("inactive write reset");

  tick_c:   cover property (@(posedge clk) disable iff (!rst_n) tick);
  trip_c:   cover property (@(posedge clk) disable iff (!rst_n) chipReset);
  write_c:  cover property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.wdata[7:6] == 2'b11);
  halt_c:   cover property (@(posedge clk) disable iff (!rst_n)
    haltExec && haltResetSuppressOption);
  pulse_end_c: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(resetPinLow_n));

endmodule

`default_nettype wire

// ==== rtl/wdt_pkg.sv ====
// Package: constants, register layout and state types of the watchdog block
// How it works
// - The count drops by one each time the prescaler completes 16000 machine cycles, giving 64 timeout steps.
// - With the watchdog active, a step of the count from 40h to 3Fh starts a chip reset.
// - A watchdog reset drives the reset pin low for a short fixed interval of about thirty microseconds.
// - The count keeps stepping at the prescaled rate even while the watchdog is inactive.
// - The six low count bits written set how many steps remain before the top bit clears.
// - The activation bit is clear after reset, can be set by software and is cleared only by reset.
// - A write with the activation bit set and the top count bit clear causes an immediate reset.
// - While active, a halt or active-halt instruction causes a reset unless the suppress option is set.
// - With the hardware option selected the watchdog is always active and the activation bit is ignored.
// - A control write does not clear the prescaler, so the first step may come anywhere in one period.
// - The control register resets to 7Fh.
// - Activation bit sits at bit 7 and the count at bits 6:0; reads return the current count.
package wdt_pkg;

  localparam int          CLK_MHZ        = 100;
  localparam int          PRESCALE_CYC   = 16000;
  localparam logic [13:0] PRESCALE_LAST  = 14'(PRESCALE_CYC - 1);
  localparam int          RST_PULSE_NS   = 30000;
  localparam logic [11:0] RST_PULSE_CYC  = 12'(RST_PULSE_NS * CLK_MHZ / 1000);

  localparam logic [3:0]  CTRL_ADDR      = 4'h0;
  localparam int          ACT_BIT        = 7;
  localparam int          TOP_BIT        = 6;
  localparam logic [7:0]  CTRL_RESET     = 8'h7f;

  typedef enum logic [0:0] {
    WDT_RUN,
    WDT_PULSE
  } wdt_state_t;

  // Register bus request from the core
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wdt_bus_t;

  // Entire state of the watchdog
  typedef struct packed {
    wdt_state_t  state;
    logic        active;
    logic [6:0]  count;
    logic [13:0] prescale;
    logic [11:0] pulse;
    logic        resetPinLow;
    logic        chipReset;
    logic [7:0]  rdata;
  } wdt_regs_t;

endpackage

// ==== bench/wdt_top_tb_top.sv ====
// Self-checking testbench of the watchdog block
`timescale 1ns/100ps
`default_nettype none
module wdt_top_tb_top;
  logic              clk, rst_n, haltExec, hwOpt, supOpt;
  logic              chipReset, resetPinLow_n, sawReset;
  logic [7:0]        rdata, rv;
  wdt_pkg::wdt_bus_t bus;
  int                mismatches, n_checks, cycles, n;
  wdt_top i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .haltExec(haltExec),
    .hwWatchdogOption(hwOpt), .haltResetSuppressOption(supOpt),
    .rdata(rdata), .chipReset(chipReset), .resetPinLow_n(resetPinLow_n));
  // Clock, hang limit well above the ~54k cycles the scenarios need
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (chipReset === 1'b1) sawReset <= 1'b1;
    if (cycles == 90000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus.addr <= a; bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic waitReset(input int lim, output int k);
    k = 0;
    #1;
    while (chipReset !== 1'b1 && k < lim) begin
      @(posedge clk); #1 k++;
    end
  endtask
  // Pin low length, then the block must come back in its reset state
  task automatic pulseCheck();
    int low = 0;
    while (resetPinLow_n === 1'b0 && low < 4000) begin
      @(posedge clk); #1 low++;
    end
    chk(low == int'(wdt_pkg::RST_PULSE_CYC), "pin pulse length");
    rdReg(4'h0, rv);
    chk(rv === 8'h7f, "state after pulse");
  endtask
  task automatic t_regs();
    rdReg(4'h0, rv);
    chk(rv === wdt_pkg::CTRL_RESET, "reset value");
    wr(4'h0, 8'hc5); rdReg(4'h0, rv);
    chk(rv === 8'hc5, "count load");
    wr(4'h0, 8'h7f); rdReg(4'h0, rv);
    chk(rv === 8'hff, "active sticky");
    wr(4'h5, 8'h40); rdReg(4'h5, rv);
    chk(rv === 8'h00, "unmapped read");
    rdReg(4'h0, rv);
    chk(rv === 8'hff, "unmapped write ignored");
  endtask
  // Two ticks: C1 to C0, then 40 to 3F one prescaler period later
  task automatic t_timeout();
    wr(4'h0, 8'hc1);
    n = 0;
    do begin
      rdReg(4'h0, rv); n++;
    end while (rv === 8'hc1 && n < 9000);
    chk(rv === 8'hc0, "prescaled step");
    waitReset(16100, n);
    chk(n >= 15990 && n <= 16002, "timeout reset");
    pulseCheck();
  endtask
  task automatic t_soft();
    wr(4'h0, 8'hff); wr(4'h0, 8'h80); waitReset(4, n);
    chk(n < 4, "software reset");
    pulseCheck();
  endtask
  // Inactive: count keeps running through 40 to 3F with no reset
  task automatic t_free();
    wr(4'h0, 8'h40);
    sawReset <= 1'b0;
    do rdReg(4'h0, rv); while (rv === 8'h40 && cycles < 80000);
    chk(rv === 8'h3f && sawReset === 1'b0, "free running");
  endtask
  // Columns: hardware option, suppress option, activate, reset expected
  task automatic t_halt();
    logic [3:0] tbl[4] = '{4'b0000, 4'b1001, 4'b0110, 4'b0011};
    foreach (tbl[i]) begin
      hwOpt <= tbl[i][3]; supOpt <= tbl[i][2];
      wr(4'h0, tbl[i][1] ? 8'hff : 8'h7f);
      @(posedge clk) haltExec <= 1'b1;
      @(posedge clk) haltExec <= 1'b0;
      waitReset(4, n);
      chk((n < 4) == tbl[i][0], "halt reset");
      if (tbl[i][0]) pulseCheck();
    end
    hwOpt <= 1'b0; supOpt <= 1'b0;
  endtask
  // Mid-run reset: activation and count must return to 7Fh
  task automatic t_rst();
    wr(4'h0, 8'hd5);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdReg(4'h0, rv);
    chk(rv === wdt_pkg::CTRL_RESET, "state after reset");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Synchronous reset held ten cycles, then the scenarios in turn
  initial begin
    rst_n = 1'b0; haltExec = 1'b0; hwOpt = 1'b0; supOpt = 1'b0;
    bus = '0; sawReset = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_timeout();
    t_soft();
    t_free();
    t_halt();
    t_rst();
    report_and_stop();
  end
endmodule
`default_nettype wire
